// ### logic/gdts_regs.svh
// Constants of the two-wire gamma reference slave.
`ifndef GDTS_REGS_SVH
`define GDTS_REGS_SVH
// ****************************************************************
// Addresses and codes on the bus
// ****************************************************************
`define GDTS_ADDR_HI 6'h3a
`define GDTS_GC_ADDR 8'h00
`define GDTS_GC_RESET 8'h06
`define GDTS_HS_CODE 5'h01
`define GDTS_LAST_CHAN 4'hb
`define GDTS_NUM_CHAN 12
// ****************************************************************
// Reset codes of channels A to L
// ****************************************************************
`define GDTS_RST_A 10'h3e0
`define GDTS_RST_B 10'h360
`define GDTS_RST_C 10'h320
`define GDTS_RST_D 10'h300
`define GDTS_RST_E 10'h2c0
`define GDTS_RST_F 10'h240
`define GDTS_RST_G 10'h1c0
`define GDTS_RST_H 10'h140
`define GDTS_RST_I 10'h100
`define GDTS_RST_J 10'h0e0
`define GDTS_RST_K 10'h0a0
`define GDTS_RST_L 10'h020
// ****************************************************************
// Glitch filter lengths in link clock samples
// ****************************************************************
`define GDTS_FLT_NORM 2'h3
`define GDTS_FLT_HS 2'h1
`endif

// ### logic/gdts_pkg.sv
// Types of the two-wire gamma reference slave.
package gdts_pkg;
  typedef logic [11:0][9:0] gdts_bank_t;
  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_RX = 6'h02,
    L_ACKS = 6'h04,
    L_TX = 6'h08,
    L_MACK = 6'h10,
    L_IGNR = 6'h20
  } gdts_lstate_t;
  typedef enum logic [1:0] {
    B_ADDR = 2'h0,
    B_PTR = 2'h1,
    B_DATA = 2'h2,
    B_GC = 2'h3
  } gdts_kind_t;
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic sel_s1;
    logic sel_s2;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_cnt;
    logic [1:0] sda_cnt;
    gdts_lstate_t state;
    gdts_kind_t kind;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic ack_next;
    logic gc_pend;
    logic sda_oe;
    logic hs;
    logic [3:0] chan;
    logic hi_phase;
    logic [1:0] hold;
    gdts_bank_t bank;
    logic dirty;
    logic req;
    logic ack_s1;
    logic ack_s2;
    gdts_bank_t snap;
  } gdts_link_t;
  typedef struct packed {
    logic rst_s1;
    logic req_s1;
    logic req_s2;
    logic seen;
    logic ld_s1;
    logic ld_s2;
    gdts_bank_t stage;
    gdts_bank_t out;
  } gdts_sys_t;
endpackage : gdts_pkg

// ### logic/gdts_slave.sv
// Two-wire slave front end with twelve 10-bit channel code registers.
`timescale 1ns/1ns
`include "gdts_regs.svh"
// Overview of operation
// [R1] Slave only; clock line is input only.
// [R2] Data falling while clock high starts transfer.
// [R3] Data rising while clock high ends transfer.
// [R4] Master keeps data stable while clock high.
// [R5] Eight data bits then one acknowledge slot.
// [R6] Acknowledge matching address on ninth clock.
// [R7] Address 111010x, low bit from select pin.
// [R8] Standard and fast speeds need no setup.
// [R9] Master sends 00001xxx code for high speed.
// [R10] Master code recognised, never acknowledged.
// [R11] Master code selects short high-speed filters.
// [R12] High speed persists across repeated starts.
// [R13] First stop returns to normal filtering.
// [R14] General call 00h then 06h resets everything.
// [R15] Always ack call address; only 06h data.
// [R16] Power-up performs the same reset.
// [R17] Reset codes 3E0 down to 020, A to L.
// [R18] Twelve channel registers of ten bits.
// [R19] Channel addresses 0000 through 1011.
// [R20] Flag zero writes, flag one reads.
// [R21] One or many consecutive channels per transaction.
// [R22] Load pin low: outputs follow registers at once.
// [R23] Pointer low nibble; only 0000-1011 acknowledged.
// [R24] High byte then low byte; commit after second.
// [R25] Early start or stop leaves channel unchanged.
// [R26] Further byte pairs advance to next channel.
// [R27] Synchronise and filter both lines before detection.
module gdts_slave
  import gdts_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic output_load_pin,
  output logic hs_active,
  output gdts_bank_t chan_code
);

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  function automatic gdts_bank_t reset_bank();
    gdts_bank_t b;
    b[0] = `GDTS_RST_A; // R17
    b[1] = `GDTS_RST_B;
    b[2] = `GDTS_RST_C;
    b[3] = `GDTS_RST_D;
    b[4] = `GDTS_RST_E;
    b[5] = `GDTS_RST_F;
    b[6] = `GDTS_RST_G;
    b[7] = `GDTS_RST_H;
    b[8] = `GDTS_RST_I;
    b[9] = `GDTS_RST_J;
    b[10] = `GDTS_RST_K;
    b[11] = `GDTS_RST_L;
    return b;
  endfunction : reset_bank

  // A line level is accepted only after it has held for lim samples.
  function automatic logic [2:0] filt(input logic raw, input logic cur,
                                      input logic [1:0] cnt, input logic [1:0] lim);
    logic [1:0] nxt;
    nxt = cnt + 2'h1;
    if (raw == cur) begin
      return {cur, 2'h0};
    end else if (nxt >= lim) begin
      return {raw, 2'h0};
    end
    return {cur, nxt};
  endfunction : filt

  // Pointer values past the last channel register are refused.
  function automatic logic chan_ok(input logic [3:0] idx);
    return idx <= `GDTS_LAST_CHAN;
  endfunction : chan_ok

  // ****************************************************************
  // Link domain: bus engine and channel registers
  // ****************************************************************
  gdts_link_t lq;
  gdts_link_t ld;

  // The system side copies snap only while req stands still, so the wide word
  // crosses without a gray code: the toggle handshake guards it.
  gdts_sys_t sq;
  gdts_sys_t sd;

  logic [2:0] scl_fv;
  logic [2:0] sda_fv;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] rx_byte;
  logic [1:0] flt_lim;

  always_comb begin
    ld = lq;

    // Every pin and the reset pass two flops before the link logic reads them.
    ld.rst_s1 = srst;
    ld.rst_s2 = lq.rst_s1;
    ld.scl_s1 = scl; // R1
    ld.scl_s2 = lq.scl_s1;
    ld.sda_s1 = sda_i;
    ld.sda_s2 = lq.sda_s1;
    ld.sel_s1 = addr_select_pin;
    ld.sel_s2 = lq.sel_s1;
    ld.ack_s1 = sq.seen;
    ld.ack_s2 = lq.ack_s1;

    // Fewer samples in high speed, as the short bit periods would not pass the long filter.
    flt_lim = lq.hs ? `GDTS_FLT_HS : `GDTS_FLT_NORM; // R11
    scl_fv = filt(lq.scl_s2, lq.scl_f, lq.scl_cnt, flt_lim); // R27
    sda_fv = filt(lq.sda_s2, lq.sda_f, lq.sda_cnt, flt_lim); // R27
    ld.scl_f = scl_fv[2];
    ld.scl_cnt = scl_fv[1:0];
    ld.sda_f = sda_fv[2];
    ld.sda_cnt = sda_fv[1:0];

    scl_rise = !lq.scl_f && ld.scl_f;
    scl_fall = lq.scl_f && !ld.scl_f;
    start_det = lq.scl_f && ld.scl_f && lq.sda_f && !ld.sda_f; // R2
    stop_det = lq.scl_f && ld.scl_f && !lq.sda_f && ld.sda_f; // R3
    rx_byte = {lq.shreg[6:0], lq.sda_f};

    // Frame conditions override whatever the byte engine is doing.
    if (start_det) begin
      // A repeated start drops a half-received pair; hs stays set.
      ld.state = L_RX; // R12
      ld.kind = B_ADDR;
      ld.bit_cnt = 4'h0;
      ld.hi_phase = 1'b0; // R25
      ld.sda_oe = 1'b0;
      ld.gc_pend = 1'b0;
    end else if (stop_det) begin
      ld.state = L_IDLE;
      ld.hs = 1'b0; // R13
      ld.hi_phase = 1'b0; // R25
      ld.sda_oe = 1'b0;
      ld.gc_pend = 1'b0;
    end else begin
      unique case (lq.state)
        L_IDLE, L_IGNR: begin
          ld.sda_oe = 1'b0;
        end

        L_RX: begin
          if (scl_rise) begin
            ld.shreg = rx_byte; // R4
            ld.bit_cnt = lq.bit_cnt + 4'h1;
          end else if (scl_fall && lq.bit_cnt == 4'h8) begin // R5
            ld.ack_next = 1'b0;
            unique case (lq.kind)
              // Own address first; general call and master code come after it.
              B_ADDR: begin
                if (lq.shreg[7:1] == {`GDTS_ADDR_HI, lq.sel_s2}) begin // R7
                  ld.ack_next = 1'b1; // R6
                  ld.rw = lq.shreg[0]; // R20
                  ld.kind = B_PTR;
                end else if (lq.shreg == `GDTS_GC_ADDR) begin
                  ld.ack_next = 1'b1; // R15
                  ld.kind = B_GC;
                end else if (lq.shreg[7:3] == `GDTS_HS_CODE) begin // R9
                  ld.hs = 1'b1; // R10
                end
              end

              B_PTR: begin
                if (chan_ok(lq.shreg[3:0])) begin // R23
                  ld.ack_next = 1'b1;
                  ld.chan = lq.shreg[3:0]; // R19
                  ld.hi_phase = 1'b0;
                  ld.kind = B_DATA;
                end
              end

              // The high byte waits in hold, so a cut pair never reaches the register.
              B_DATA: begin
                if (chan_ok(lq.chan)) begin
                  ld.ack_next = 1'b1;
                  if (!lq.hi_phase) begin
                    ld.hold = lq.shreg[1:0]; // R24
                    ld.hi_phase = 1'b1;
                  end else begin
                    ld.bank[lq.chan] = {lq.hold, lq.shreg}; // R24
                    ld.dirty = 1'b1;
                    ld.hi_phase = 1'b0;
                    ld.chan = lq.chan + 4'h1; // R26
                  end
                end
              end

              // Only the reset code is acknowledged after a general call.
              B_GC: begin
                if (lq.shreg == `GDTS_GC_RESET) begin // R15
                  ld.ack_next = 1'b1;
                  ld.gc_pend = 1'b1;
                end
              end

              default: begin
                ld.ack_next = 1'b0;
              end
            endcase
            if (ld.ack_next) begin
              ld.state = L_ACKS;
              ld.sda_oe = 1'b1; // R6
            end else begin
              ld.state = L_IGNR; // R10
            end
          end
        end

        // The acknowledge slot ends on the falling clock; the byte engine restarts here.
        L_ACKS: begin
          if (scl_fall) begin
            ld.sda_oe = 1'b0;
            ld.bit_cnt = 4'h0;
            if (lq.gc_pend) begin
              // Same reset as power-up; the engine then waits for the next start.
              ld.bank = reset_bank(); // R14
              ld.chan = 4'h0;
              ld.hs = 1'b0;
              ld.hi_phase = 1'b0;
              ld.gc_pend = 1'b0;
              ld.dirty = 1'b1;
              ld.state = L_IGNR;
            end else if (lq.kind == B_PTR && lq.rw) begin
              // A read starts at the channel held by the pointer.
              ld.state = L_TX; // R20
              ld.hi_phase = 1'b0;
              ld.shreg = {6'h00, lq.bank[lq.chan][9:8]};
              ld.sda_oe = 1'b1; // R5
            end else begin
              ld.state = L_RX;
            end
          end
        end

        // Data moves on the falling clock so it is settled when the master samples.
        L_TX: begin
          if (scl_fall) begin
            ld.bit_cnt = lq.bit_cnt + 4'h1;
            if (lq.bit_cnt == 4'h7) begin
              ld.state = L_MACK;
              ld.sda_oe = 1'b0;
            end else begin
              ld.shreg = {lq.shreg[6:0], 1'b0};
              ld.sda_oe = !lq.shreg[6];
            end
          end
        end

        // The master's acknowledge decides whether another byte is shifted out.
        L_MACK: begin
          if (scl_rise) begin
            ld.ack_next = !ld.sda_f;
          end else if (scl_fall) begin
            ld.bit_cnt = 4'h0;
            if (!lq.ack_next) begin
              ld.state = L_IGNR;
            end else if (!lq.hi_phase) begin
              ld.hi_phase = 1'b1;
              ld.state = L_TX;
              ld.shreg = lq.bank[lq.chan][7:0]; // R24
              ld.sda_oe = !lq.bank[lq.chan][7];
            end else if (lq.chan < `GDTS_LAST_CHAN) begin
              ld.hi_phase = 1'b0;
              ld.chan = lq.chan + 4'h1; // R21
              ld.state = L_TX;
              ld.shreg = {6'h00, lq.bank[ld.chan][9:8]};
              // The top bit of a high byte is always zero, so the line is pulled low.
              ld.sda_oe = 1'b1;
            end else begin
              ld.state = L_IGNR;
            end
          end
        end

        default: begin
          ld.state = L_IDLE;
          ld.sda_oe = 1'b0;
        end
      endcase
    end

    // Hand a snapshot over only when the previous one was taken.
    // One snapshot holds all twelve codes, so an update moves as a whole.
    if (lq.dirty && lq.req == lq.ack_s2) begin
      ld.snap = lq.bank;
      ld.req = !lq.req;
      ld.dirty = ld.dirty && (ld.bank != lq.bank);
    end

    // Reset wins over everything above, bus activity included.
    if (lq.rst_s2) begin
      ld.state = L_IDLE; // R16
      ld.kind = B_ADDR;
      ld.bit_cnt = 4'h0;
      ld.shreg = 8'h00;
      ld.rw = 1'b0;
      ld.ack_next = 1'b0;
      ld.gc_pend = 1'b0;
      ld.sda_oe = 1'b0;
      ld.hs = 1'b0; // R8
      ld.chan = 4'h0;
      ld.hi_phase = 1'b0;
      ld.hold = 2'h0;
      ld.bank = reset_bank(); // R16
      ld.dirty = 1'b0;
      ld.req = 1'b0;
      ld.snap = reset_bank();
      // Filtered lines reset to the idle level, so no false frame edge follows reset.
      ld.scl_f = 1'b1;
      ld.sda_f = 1'b1;
      ld.scl_cnt = 2'h0;
      ld.sda_cnt = 2'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    lq <= ld;
  end

  // ****************************************************************
  // System domain: channel outputs
  // ****************************************************************
  always_comb begin
    sd = sq;
    sd.rst_s1 = srst;
    sd.req_s1 = lq.req;
    sd.req_s2 = sq.req_s1;

    // The load pin comes from outside, so it is synchronised too.
    sd.ld_s1 = output_load_pin;
    sd.ld_s2 = sq.ld_s1;
    if (sq.req_s2 != sq.seen) begin
      sd.stage = lq.snap;
      sd.seen = sq.req_s2;
    end
    // With the load pin high the outputs hold; staged codes wait for it to drop.
    if (!sq.ld_s2) begin
      sd.out = sq.stage; // R22
    end
    if (srst) begin
      sd.seen = 1'b0;
      sd.stage = reset_bank(); // R18
      sd.out = reset_bank();
    end
  end

  always_ff @(posedge clk) begin
    sq <= sd;
  end

  // Open drain: the data pin only ever pulls low, and the clock pin is never driven.
  assign sda_o = 1'b0;
  assign sda_oe = lq.sda_oe;
  assign hs_active = lq.hs;
  assign chan_code = sq.out;

endmodule : gdts_slave

// ### dv/gdts_master.sv
// Behavioural two-wire bus master driving the slave's clock and data pins.
`timescale 1ns/1ns
module gdts_master (
  input wire logic link_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic pull = 1'b0;
  int ph = 8;
  initial scl = 1'b1;
  // Open drain with pull-up: a released line rises, either party may pull it low.
  assign sda = !(pull || (sda_oe && !sda_o));
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #2;
  endtask : tick
  // Data moves only well after the clock falls, so the slave never sees a false frame edge.
  task automatic bitx(input logic b, output logic r);
    tick(2);
    pull = !b;
    tick(ph);
    scl = 1'b1;
    tick(ph);
    r = sda;
    scl = 1'b0;
  endtask : bitx
  task automatic start();
    tick(2);
    pull = 1'b0;
    tick(ph);
    scl = 1'b1;
    tick(ph);
    pull = 1'b1;
    tick(ph);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    pull = 1'b1;
    tick(ph);
    scl = 1'b1;
    tick(ph);
    pull = 1'b0;
    tick(ph);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(!mack, r);
    ack = !r;
  endtask : xfer
endmodule : gdts_master

// ### dv/gdts_slave_sva.sv
// Concurrent checks on the ports of the two-wire gamma reference slave.
`timescale 1ns/1ns
`include "gdts_regs.svh"
module gdts_slave_sva
  import gdts_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic output_load_pin,
  input wire logic hs_active,
  input wire gdts_bank_t chan_code
);
  localparam gdts_bank_t RST_CODES = {`GDTS_RST_L, `GDTS_RST_K, `GDTS_RST_J, `GDTS_RST_I,
    `GDTS_RST_H, `GDTS_RST_G, `GDTS_RST_F, `GDTS_RST_E, `GDTS_RST_D, `GDTS_RST_C,
    `GDTS_RST_B, `GDTS_RST_A};
  pin_open_drain_a:
    assert property (@(posedge link_clk) sda_o == 1'b0) else $error("Data pin driven high.");
  reset_codes_a:
    assert property (@(posedge clk) disable iff (srst) $fell(srst) |-> chan_code == RST_CODES)
    else $error("Reset codes wrong.");
  ack_low_phase_a:
    assert property (@(posedge link_clk) disable iff (srst) $changed(sda_oe) |-> !scl)
    else $error("Data drive changed with clock high.");
  ack_stands_a:
    assert property (@(posedge link_clk) disable iff (srst) $rose(sda_oe) |=> sda_oe[*4])
    else $error("Acknowledge too short.");
  no_ack_idle_a:
    assert property (@(posedge link_clk) disable iff (srst) scl[*8] |-> !$rose(sda_oe))
    else $error("Drive began outside a low phase.");
  hs_no_ack_a:
    assert property (@(posedge link_clk) disable iff (srst) $rose(hs_active) |-> !sda_oe[*4])
    else $error("Master code acknowledged.");
  hs_stop_exit_a:
    assert property (@(posedge link_clk) disable iff (srst) $fell(hs_active) |-> scl && sda_i)
    else $error("High speed left without stop.");
  load_hold_a:
    assert property (@(posedge clk) disable iff (srst) output_load_pin[*4] |=> $stable(chan_code))
    else $error("Outputs moved while load held.");
  link_reset_a:
    assert property (@(posedge link_clk) srst[*5] |-> !sda_oe && !hs_active)
    else $error("Link side not reset.");
endmodule : gdts_slave_sva
bind gdts_slave gdts_slave_sva i_sva (.clk(clk), .srst(srst), .link_clk(link_clk), .scl(scl),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
  .output_load_pin(output_load_pin), .hs_active(hs_active), .chan_code(chan_code));

// ### dv/gdts_slave_tb.sv
// Self-checking bench of the two-wire gamma reference slave.
`timescale 1ns/1ns
`include "gdts_regs.svh"
module gdts_slave_tb
  import gdts_pkg::*;
;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic sel = 1'b0;
  logic load = 1'b0;
  logic scl, sda, sda_o, sda_oe, hs_active, a;
  gdts_bank_t chan_code;
  logic [31:0] rnd = 32'hd522_955e;
  logic [9:0] ex [12];
  logic [7:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  initial forever #20 clk = !clk;
  initial begin
    #7;
    forever #32 link_clk = !link_clk;
  end
  gdts_slave i_dut (.clk(clk), .srst(srst), .link_clk(link_clk), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin(sel), .output_load_pin(load),
    .hs_active(hs_active), .chan_code(chan_code));
  gdts_master i_mst (.link_clk(link_clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic wb(input logic [7:0] d, input logic e);
    i_mst.xfer(d, 1'b0, q, a);
    chk("ack", 10'(e), 10'(a));
  endtask : wb
  // The crossing settles within a few clocks; twelve leave margin for the slowest phase.
  task automatic cb();
    repeat (12) @(posedge clk);
    #2;
    for (int i = 0; i < 12; i++) chk("chan_code", ex[i], chan_code[i]);
  endtask : cb
  task automatic pins(input logic s, input logic l);
    @(posedge clk);
    #2;
    sel = s;
    load = l;
  endtask : pins
  task automatic set_rst();
    ex = '{`GDTS_RST_A, `GDTS_RST_B, `GDTS_RST_C, `GDTS_RST_D, `GDTS_RST_E, `GDTS_RST_F,
      `GDTS_RST_G, `GDTS_RST_H, `GDTS_RST_I, `GDTS_RST_J, `GDTS_RST_K, `GDTS_RST_L};
  endtask : set_rst
  initial begin
    #2_000_000;
    error_cnt++;
    conclude();
  end
  initial begin
    set_rst();
    repeat (16) @(posedge clk);
    #2 srst = 1'b0;
    cb();
    i_mst.start();
    wb(8'he8, 1'b1);
    wb(8'h00, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      ex[i] = rnd[9:0];
      wb(rnd[15:8], 1'b1);
      wb(rnd[7:0], 1'b1);
    end
    wb(8'h12, 1'b0);
    i_mst.stop();
    cb();
    pins(1'b1, 1'b0);
    i_mst.start();
    wb(8'he8, 1'b0);
    i_mst.start();
    wb(8'hea, 1'b1);
    wb(8'h0c, 1'b0);
    i_mst.start();
    wb(8'hea, 1'b1);
    wb(8'hf3, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h55, 1'b1);
    ex[3] = 10'h155;
    wb(8'h02, 1'b1);
    i_mst.stop();
    cb();
    i_mst.start();
    wb(8'hea, 1'b1);
    wb(8'h0a, 1'b1);
    i_mst.start();
    wb(8'heb, 1'b1);
    for (int i = 0; i < 4; i++) begin
      i_mst.xfer(8'hff, i < 3, q, a);
      if (i[0]) chk("read lo", 10'(ex[10 + i / 2][7:0]), 10'(q));
      else chk("read hi", 10'(ex[10 + i / 2][9:8]), 10'(q[1:0]));
    end
    i_mst.stop();
    pins(1'b1, 1'b1);
    i_mst.start();
    wb(8'hea, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h11, 1'b1);
    i_mst.stop();
    cb();
    ex[0] = 10'h011;
    pins(1'b1, 1'b0);
    cb();
    i_mst.start();
    wb(8'h0b, 1'b0);
    i_mst.start();
    chk("hs_active", 10'h001, 10'(hs_active));
    i_mst.ph = 5;
    wb(8'hea, 1'b1);
    wb(8'h05, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'h9c, 1'b1);
    ex[5] = 10'h29c;
    i_mst.start();
    chk("hs_active", 10'h001, 10'(hs_active));
    wb(8'hea, 1'b1);
    i_mst.stop();
    i_mst.ph = 8;
    i_mst.tick(8);
    chk("hs_active", 10'h000, 10'(hs_active));
    cb();
    i_mst.start();
    wb(8'h00, 1'b1);
    wb(8'h05, 1'b0);
    i_mst.stop();
    cb();
    i_mst.start();
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    i_mst.stop();
    set_rst();
    cb();
    conclude();
  end
endmodule : gdts_slave_tb
